// [bus_unit_map_pkg.sv]
// Constants for the bus interface unit memory map register bank.
// Assumes a single 125 MHz clock domain shared by every user.
package bus_unit_map_pkg;

	// Register window and offsets, relative to the configuration base
	localparam logic [15:0] WIN_BASE = 16'h8000;
	localparam logic [15:0] WIN_SIZE = 16'h0100;
	localparam logic [15:0] OFF_MEMORY_TOP = 16'h8000;
	localparam logic [15:0] OFF_MAP_AB = 16'h8004;
	localparam logic [15:0] OFF_MAP_CD = 16'h8008;
	localparam logic [15:0] OFF_MAP_EF = 16'h800c;

	// Reset values
	localparam logic [31:0] RST_MEMORY_TOP = 32'h3fffffff;
	localparam logic [31:0] RST_MAP = 32'h00000000;

	// Memory top field
	localparam int TOP_CODE_LSB = 17;
	localparam int TOP_CODE_MSB = 27;

	// Fields of the A/B map register
	localparam int UPPER_REDIRECT_BIT = 28;
	localparam int UPPER_CTL_LSB = 24;
	localparam int PCI_REG_EN_BIT = 22;
	localparam int ADDR20_MASK_BIT = 21;
	localparam int LOWER_REDIRECT_BIT = 20;
	localparam int LOWER_CTL_LSB = 16;
	localparam int IO_3DX_SMI_BIT = 15;
	localparam int IO_3CX_SMI_BIT = 14;

	// Bits of a four-bit region control field
	localparam int CTL_READ_BIT = 0;
	localparam int CTL_WRITE_BIT = 1;
	localparam int CTL_CACHE_BIT = 2;
	localparam int CTL_PCI_MASTER_BIT = 3;

	// Address windows
	localparam logic [19:0] LOWER_WIN_LO = 20'hb0000;
	localparam logic [19:0] LOWER_WIN_HI = 20'hb7fff;
	localparam logic [19:0] UPPER_WIN_LO = 20'hb8000;
	localparam logic [19:0] UPPER_WIN_HI = 20'hbffff;
	localparam logic [19:0] SEG_AREA_LO = 20'hc0000;
	localparam logic [19:0] SEG_AREA_HI = 20'hfffff;
	localparam int SEG_SHIFT = 14;
	localparam logic [15:0] IO_3CX_BASE = 16'h03c0;
	localparam logic [15:0] IO_3DX_BASE = 16'h03d0;

endpackage

// [region_decode.sv]
// Combinational decode of a 20-bit low-memory address against the region map.
// Assumes the caller registers the results and masks address bit 20 first.
module region_decode
	import bus_unit_map_pkg::*;
(
	input wire logic [31:0] addr,
	input wire logic [31:0] map_ab,
	input wire logic [31:0] map_cd,
	input wire logic [31:0] map_ef,
	output logic hit,
	output logic [3:0] ctl,
	output logic to_graphics
);

	logic [19:0] a;
	logic low_meg;
	logic [2:0] seg;

	assign a = addr[19:0];
	assign low_meg = (addr[31:20] == 12'h000);
	assign seg = a[SEG_SHIFT+2:SEG_SHIFT];

	// Select the control field and graphics routing for the address
	always_comb
	begin
		hit = 1'b0;
		ctl = 4'h0;
		to_graphics = 1'b0;
		if (low_meg && a >= UPPER_WIN_LO && a <= UPPER_WIN_HI)
		begin
			hit = 1'b1;
			ctl = map_ab[UPPER_CTL_LSB +: 4];
			to_graphics = map_ab[UPPER_REDIRECT_BIT];
			// Redirected window never caches, whatever its field says
			if (map_ab[UPPER_REDIRECT_BIT])
				ctl[CTL_CACHE_BIT] = 1'b0;
		end
		else if (low_meg && a >= LOWER_WIN_LO && a <= LOWER_WIN_HI)
		begin
			hit = 1'b1;
			ctl = map_ab[LOWER_CTL_LSB +: 4];
			to_graphics = map_ab[LOWER_REDIRECT_BIT];
			if (map_ab[LOWER_REDIRECT_BIT])
				ctl[CTL_CACHE_BIT] = 1'b0;
		end
		else if (low_meg && a >= SEG_AREA_LO && a <= SEG_AREA_HI)
		begin
			// 16 KB segments, eight per map register
			hit = 1'b1;
			if (a[17])
				ctl = map_ef[{seg, 2'b00} +: 4];
			else
				ctl = map_cd[{seg, 2'b00} +: 4];
		end
	end

endmodule

// [bus_unit_map_regs.sv]
// Memory map register bank of the internal bus interface unit, with the
// address decode that the registers steer.
// Assumes requests come from logic on ref_clk; offsets are relative to the
// configuration base, which is decoded upstream.
module bus_unit_map_regs
	import bus_unit_map_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst,
	// Register access port
	input wire logic reg_req,
	input wire logic reg_write,
	input wire logic [15:0] reg_addr,
	input wire logic [3:0] reg_be,
	input wire logic [31:0] reg_wdata,
	output logic reg_ack,
	output logic [31:0] reg_rdata,
	// Memory access decode
	input wire logic mem_valid,
	input wire logic [31:0] mem_addr,
	input wire logic mem_smi,
	output logic mem_out_valid,
	output logic [31:0] mem_addr_out,
	output logic mem_below_top,
	output logic mem_region_hit,
	output logic mem_to_graphics,
	output logic mem_read_ok,
	output logic mem_write_ok,
	output logic mem_cacheable,
	output logic mem_pci_master_ok,
	// I/O access trap
	input wire logic io_valid,
	input wire logic [15:0] io_addr,
	output logic io_smi,
	// PCI slave access to internal registers
	input wire logic pci_reg_req,
	output logic pci_reg_grant,
	output logic pci_reg_refuse
);
	import bus_unit_map_pkg::*;

	// Register state
	logic [31:0] memory_top_limit_q;
	logic [31:0] memory_top_limit_d;
	logic [31:0] xbus_map_a_b_regions_q;
	logic [31:0] xbus_map_a_b_regions_d;
	logic [31:0] xbus_map_c_d_regions_q;
	logic [31:0] xbus_map_c_d_regions_d;
	logic [31:0] xbus_map_e_f_regions_q;
	logic [31:0] xbus_map_e_f_regions_d;
	logic reg_ack_q;
	logic reg_ack_d;
	logic [31:0] reg_rdata_q;
	logic [31:0] reg_rdata_d;

	// Access decode state
	logic mem_out_valid_q;
	logic mem_out_valid_d;
	logic [31:0] mem_addr_out_q;
	logic [31:0] mem_addr_out_d;
	logic mem_below_top_q;
	logic mem_below_top_d;
	logic mem_region_hit_q;
	logic mem_region_hit_d;
	logic mem_to_graphics_q;
	logic mem_to_graphics_d;
	logic [3:0] mem_perm_q;
	logic [3:0] mem_perm_d;
	logic io_smi_q;
	logic io_smi_d;
	logic pci_reg_grant_q;
	logic pci_reg_grant_d;
	logic pci_reg_refuse_q;
	logic pci_reg_refuse_d;

	// Decoded named fields of the A/B map register
	logic upper_display_window_redirect;
	logic lower_display_window_redirect;
	logic [3:0] upper_display_window_ctl;
	logic [3:0] lower_display_window_ctl;
	logic pci_internal_reg_access_en;
	logic addr_bit20_mask;
	logic io_3dx_smi_en;
	logic io_3cx_smi_en;

	// Helpers for the memory path and the register window
	logic [31:0] masked_addr;
	logic rd_hit;
	logic [3:0] rd_ctl;
	logic rd_graphics;
	logic in_window;

	// Merge a write into a stored word one byte lane at a time
	function automatic logic [31:0] merge_bytes(input logic [31:0] old_val,
		input logic [31:0] new_val, input logic [3:0] be);
		logic [31:0] res;
		res = old_val;
		for (int i = 0; i < 4; i++)
		begin
			if (be[i])
				res[i*8 +: 8] = new_val[i*8 +: 8];
		end
		return res;
	endfunction

	// True when an I/O address falls inside a 16-port block
	function automatic logic io_in_block(input logic [15:0] addr, input logic [15:0] base);
		return (addr[15:4] == base[15:4]);
	endfunction

	// Named views of the A/B map register fields
	assign upper_display_window_redirect = xbus_map_a_b_regions_q[UPPER_REDIRECT_BIT];
	assign upper_display_window_ctl = xbus_map_a_b_regions_q[UPPER_CTL_LSB +: 4];
	assign pci_internal_reg_access_en = xbus_map_a_b_regions_q[PCI_REG_EN_BIT];
	assign addr_bit20_mask = xbus_map_a_b_regions_q[ADDR20_MASK_BIT];
	assign lower_display_window_redirect = xbus_map_a_b_regions_q[LOWER_REDIRECT_BIT];
	assign lower_display_window_ctl = xbus_map_a_b_regions_q[LOWER_CTL_LSB +: 4];
	assign io_3dx_smi_en = xbus_map_a_b_regions_q[IO_3DX_SMI_BIT];
	assign io_3cx_smi_en = xbus_map_a_b_regions_q[IO_3CX_SMI_BIT];

	// Window decode: the whole 100h bytes answer, only four words hold data
	assign in_window = (reg_addr >= WIN_BASE) && (reg_addr < WIN_BASE + WIN_SIZE);

	// Register writes and read data, computed for the next edge
	always_comb
	begin
		memory_top_limit_d = memory_top_limit_q;
		xbus_map_a_b_regions_d = xbus_map_a_b_regions_q;
		xbus_map_c_d_regions_d = xbus_map_c_d_regions_q;
		xbus_map_e_f_regions_d = xbus_map_e_f_regions_q;
		reg_ack_d = 1'b0;
		reg_rdata_d = 32'h00000000;
		if (reg_req && in_window)
		begin
			reg_ack_d = 1'b1;
			if (reg_write)
			begin
				// Stored whole so software's fill bits read back as written
				unique case ({reg_addr[15:2], 2'b00})
					OFF_MEMORY_TOP:
						memory_top_limit_d = merge_bytes(memory_top_limit_q,
							reg_wdata, reg_be);
					OFF_MAP_AB:
						xbus_map_a_b_regions_d = merge_bytes(xbus_map_a_b_regions_q,
							reg_wdata, reg_be);
					OFF_MAP_CD:
						xbus_map_c_d_regions_d = merge_bytes(xbus_map_c_d_regions_q,
							reg_wdata, reg_be);
					OFF_MAP_EF:
						xbus_map_e_f_regions_d = merge_bytes(xbus_map_e_f_regions_q,
							reg_wdata, reg_be);
					default:
						; // Undefined offsets take no write
				endcase
			end
			else
			begin
				unique case ({reg_addr[15:2], 2'b00})
					OFF_MEMORY_TOP:
						reg_rdata_d = memory_top_limit_q;
					OFF_MAP_AB:
						reg_rdata_d = xbus_map_a_b_regions_q;
					OFF_MAP_CD:
						reg_rdata_d = xbus_map_c_d_regions_q;
					OFF_MAP_EF:
						reg_rdata_d = xbus_map_e_f_regions_q;
					default:
						reg_rdata_d = 32'h00000000;
				endcase
			end
		end
	end

	// Register bank flops
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			memory_top_limit_q <= RST_MEMORY_TOP;
			xbus_map_a_b_regions_q <= RST_MAP;
			xbus_map_c_d_regions_q <= RST_MAP;
			xbus_map_e_f_regions_q <= RST_MAP;
			reg_ack_q <= 1'b0;
			reg_rdata_q <= 32'h00000000;
		end
		else
		begin
			memory_top_limit_q <= memory_top_limit_d;
			xbus_map_a_b_regions_q <= xbus_map_a_b_regions_d;
			xbus_map_c_d_regions_q <= xbus_map_c_d_regions_d;
			xbus_map_e_f_regions_q <= xbus_map_e_f_regions_d;
			reg_ack_q <= reg_ack_d;
			reg_rdata_q <= reg_rdata_d;
		end
	end

	// Bit 20 wrap for legacy software; SMI handlers see the real address
	always_comb
	begin
		masked_addr = mem_addr;
		if (addr_bit20_mask && !mem_smi)
			masked_addr[20] = 1'b0;
	end

	// Region lookup on the masked address
	region_decode u_region_decode (
		.addr(masked_addr),
		.map_ab(xbus_map_a_b_regions_q),
		.map_cd(xbus_map_c_d_regions_q),
		.map_ef(xbus_map_e_f_regions_q),
		.hit(rd_hit),
		.ctl(rd_ctl),
		.to_graphics(rd_graphics)
	);

	// Memory decode results, one cycle after the access is presented
	always_comb
	begin
		mem_out_valid_d = mem_valid;
		mem_addr_out_d = mem_valid ? masked_addr : mem_addr_out_q;
		mem_below_top_d = 1'b0;
		mem_region_hit_d = 1'b0;
		mem_to_graphics_d = 1'b0;
		mem_perm_d = 4'h0;
		if (mem_valid)
		begin
			// Top compares on the code bits; low bits are all ones by use
			mem_below_top_d = (masked_addr[31:TOP_CODE_LSB] <=
				{4'h0, memory_top_limit_q[TOP_CODE_MSB:TOP_CODE_LSB]});
			mem_region_hit_d = rd_hit;
			mem_to_graphics_d = rd_graphics;
			// Outside the controlled regions nothing is restricted
			mem_perm_d = rd_hit ? rd_ctl : 4'hf;
		end
	end

	// Memory decode flops
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			mem_out_valid_q <= 1'b0;
			mem_addr_out_q <= 32'h00000000;
			mem_below_top_q <= 1'b0;
			mem_region_hit_q <= 1'b0;
			mem_to_graphics_q <= 1'b0;
			mem_perm_q <= 4'h0;
		end
		else
		begin
			mem_out_valid_q <= mem_out_valid_d;
			mem_addr_out_q <= mem_addr_out_d;
			mem_below_top_q <= mem_below_top_d;
			mem_region_hit_q <= mem_region_hit_d;
			mem_to_graphics_q <= mem_to_graphics_d;
			mem_perm_q <= mem_perm_d;
		end
	end

	// I/O trap and PCI slave gate, one cycle pulses
	always_comb
	begin
		io_smi_d = io_valid &&
			((io_3dx_smi_en && io_in_block(io_addr, IO_3DX_BASE)) ||
			(io_3cx_smi_en && io_in_block(io_addr, IO_3CX_BASE)));
		pci_reg_grant_d = pci_reg_req && pci_internal_reg_access_en;
		pci_reg_refuse_d = pci_reg_req && !pci_internal_reg_access_en;
	end

	// Trap and gate flops
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			io_smi_q <= 1'b0;
			pci_reg_grant_q <= 1'b0;
			pci_reg_refuse_q <= 1'b0;
		end
		else
		begin
			io_smi_q <= io_smi_d;
			pci_reg_grant_q <= pci_reg_grant_d;
			pci_reg_refuse_q <= pci_reg_refuse_d;
		end
	end

	// Outputs straight from flops
	assign reg_ack = reg_ack_q;
	assign reg_rdata = reg_rdata_q;
	assign mem_out_valid = mem_out_valid_q;
	assign mem_addr_out = mem_addr_out_q;
	assign mem_below_top = mem_below_top_q;
	assign mem_region_hit = mem_region_hit_q;
	assign mem_to_graphics = mem_to_graphics_q;
	assign mem_read_ok = mem_perm_q[CTL_READ_BIT];
	assign mem_write_ok = mem_perm_q[CTL_WRITE_BIT];
	assign mem_cacheable = mem_perm_q[CTL_CACHE_BIT];
	assign mem_pci_master_ok = mem_perm_q[CTL_PCI_MASTER_BIT];
	assign io_smi = io_smi_q;
	assign pci_reg_grant = pci_reg_grant_q;
	assign pci_reg_refuse = pci_reg_refuse_q;

endmodule

// [bus_unit_map_regs_assertions.sv]
// Checker for the memory map register bank, watching its ports only.
// Assumes one ref_clk domain and a synchronous active-high rst.
module bus_unit_map_regs_checker (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic reg_req,
	input wire logic [15:0] reg_addr,
	input wire logic reg_ack,
	input wire logic [31:0] reg_rdata,
	input wire logic mem_valid,
	input wire logic [31:0] mem_addr,
	input wire logic mem_smi,
	input wire logic mem_out_valid,
	input wire logic [31:0] mem_addr_out,
	input wire logic mem_region_hit,
	input wire logic mem_to_graphics,
	input wire logic mem_read_ok,
	input wire logic mem_cacheable,
	input wire logic io_valid,
	input wire logic [15:0] io_addr,
	input wire logic io_smi,
	input wire logic pci_reg_req,
	input wire logic pci_reg_grant,
	input wire logic pci_reg_refuse
);
	timeunit 1ns;
	timeprecision 1ps;

	// All checks share the one clock; reset mutes them
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);

	// Register port answers only inside the 100h-byte window
	a_ack_in_window: assert property (reg_req && reg_addr[15:8] == 8'h80 |=> reg_ack)
		else $error("register request in window not acknowledged");
	a_no_ack_outside: assert property (reg_req && reg_addr[15:8] != 8'h80
		|=> !reg_ack)
		else $error("register request outside window acknowledged");
	a_rdata_quiet: assert property (!reg_ack |-> reg_rdata == 32'h0)
		else $error("read data not zero without acknowledge");
	// Exactly one of grant or refuse answers each slave request
	a_pci_answer: assert property (pci_reg_req |=> pci_reg_grant != pci_reg_refuse)
		else $error("slave request not answered once");
	// Trap only for 3C0h-3DFh, one cycle after the access
	a_io_range: assert property (io_smi
		|-> $past(io_valid) && $past(io_addr[15:5]) == 11'h01e)
		else $error("io trap outside its ranges");
	// Address passes untouched apart from bit 20, and wholly for SMI accesses
	a_smi_bypass: assert property (mem_valid && mem_smi
		|=> mem_addr_out == $past(mem_addr))
		else $error("smi access address altered");
	a_mask_bits: assert property (mem_valid |=> mem_out_valid
		&& {mem_addr_out[31:21], mem_addr_out[19:0]} == $past({mem_addr[31:21], mem_addr[19:0]}))
		else $error("address bits other than 20 altered");
	a_hit_range: assert property (mem_out_valid
		|-> mem_region_hit == (mem_addr_out[31:16] inside {[16'h000b:16'h000f]}))
		else $error("region hit wrong for address");
	// Redirection only in the two display windows, never cacheable there
	a_gfx_window: assert property (mem_to_graphics
		|-> mem_out_valid && !mem_cacheable && mem_addr_out[31:16] == 16'h000b)
		else $error("graphics redirection wrong");
	a_idle_flags: assert property (!mem_out_valid
		|-> !mem_read_ok && !mem_to_graphics)
		else $error("access flags set without an access");

	c_graphics: cover property (mem_to_graphics);
	c_grant: cover property (pci_reg_grant);
	c_io_trap: cover property (io_smi);
endmodule

bind bus_unit_map_regs bus_unit_map_regs_checker chk_u (.ref_clk, .rst, .reg_req, .reg_addr,
	.reg_ack, .reg_rdata, .mem_valid, .mem_addr, .mem_smi, .mem_out_valid, .mem_addr_out,
	.mem_region_hit, .mem_to_graphics, .mem_read_ok, .mem_cacheable, .io_valid, .io_addr,
	.io_smi, .pci_reg_req, .pci_reg_grant, .pci_reg_refuse);

// [cpu_bus_master_model.sv]
// Processor-side master that issues register accesses to the bank.
// Assumes the bench calls access from one process, on ref_clk.
module cpu_bus_master_model (
	input wire logic ref_clk,
	output logic reg_req,
	output logic reg_write,
	output logic [15:0] reg_addr,
	output logic [3:0] reg_be,
	output logic [31:0] reg_wdata,
	input wire logic reg_ack,
	input wire logic [31:0] reg_rdata
);
	timeunit 1ns;
	timeprecision 1ps;

	// Quiet bus at start
	initial
	begin
		reg_req = 1'h0;
		reg_write = 1'h0;
		reg_addr = 16'h0;
		reg_be = 4'h0;
		reg_wdata = 32'h0;
	end

	// One-cycle request off the falling edge; idle address and data flip so stale data never looks valid
	task automatic access(input logic w, input logic [15:0] a, input logic [3:0] be,
		input logic [31:0] d, output logic ack, output logic [31:0] q);
		@(negedge ref_clk);
		reg_req = 1'h1;
		reg_write = w;
		reg_addr = a;
		reg_be = be;
		reg_wdata = d;
		@(negedge ref_clk);
		ack = reg_ack;
		q = reg_rdata;
		reg_req = 1'h0;
		reg_addr = ~a;
		reg_wdata = ~d;
	endtask
endmodule

// [test_bus_unit_memory_map_regs.sv]
// Self-checking bench for the memory map register bank.
// Assumes the package, the design, the master model and the checker are compiled first.
module test_bus_unit_memory_map_regs;
	timeunit 1ns;
	timeprecision 1ps;
	import bus_unit_map_pkg::*;

	logic ref_clk = 1'h0, rst = 1'h1, reg_req, reg_write, reg_ack, mem_valid = 1'h0, mem_smi = 1'h0;
	logic [15:0] reg_addr, io_addr = 16'h0;
	logic [3:0] reg_be;
	logic [31:0] reg_wdata, reg_rdata, mem_addr = 32'h0, mem_addr_out;
	logic mem_out_valid, mem_below_top, mem_region_hit, mem_to_graphics, mem_read_ok;
	logic mem_write_ok, mem_cacheable, mem_pci_master_ok, io_valid = 1'h0, io_smi;
	logic pci_reg_req = 1'h0, pci_reg_grant, pci_reg_refuse;
	int fails = 0, checks_done = 0, cycles = 0;

	bus_unit_map_regs dut_u (.ref_clk, .rst, .reg_req, .reg_write, .reg_addr, .reg_be,
		.reg_wdata, .reg_ack, .reg_rdata, .mem_valid, .mem_addr, .mem_smi, .mem_out_valid,
		.mem_addr_out, .mem_below_top, .mem_region_hit, .mem_to_graphics, .mem_read_ok,
		.mem_write_ok, .mem_cacheable, .mem_pci_master_ok, .io_valid, .io_addr, .io_smi,
		.pci_reg_req, .pci_reg_grant, .pci_reg_refuse);
	cpu_bus_master_model cpu_u (.ref_clk, .reg_req, .reg_write, .reg_addr, .reg_be,
		.reg_wdata, .reg_ack, .reg_rdata);

	initial
	begin
		forever #4 ref_clk = ~ref_clk;
	end

	task automatic test_done();
		$display("checks %0d fails %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// A hung handshake cannot stall the run past this many cycles
	always @(posedge ref_clk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			fails++;
			test_done();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			fails++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [15:0] a, input logic [3:0] be, input logic [31:0] d);
		logic k;
		logic [31:0] q;
		cpu_u.access(1'h1, a, be, d, k, q);
	endtask

	task automatic rd(input logic [15:0] a, input logic ea, input logic [31:0] ed);
		logic k;
		logic [31:0] q;
		cpu_u.access(1'h0, a, 4'hf, 32'h0, k, q);
		check(32'(k), 32'(ea));
		check(q, ed);
	endtask

	// One access in, decode flags a cycle later; idle address flips afterwards
	task automatic mem_chk(input logic [31:0] a, input logic s, input logic [31:0] eo,
		input logic [6:0] ef);
		@(negedge ref_clk);
		mem_valid = 1'h1;
		mem_addr = a;
		mem_smi = s;
		@(negedge ref_clk);
		mem_valid = 1'h0;
		mem_addr = ~a;
		check(32'(mem_out_valid), 32'h1);
		check(mem_addr_out, eo);
		check(32'({mem_below_top, mem_region_hit, mem_to_graphics, mem_read_ok,
			mem_write_ok, mem_cacheable, mem_pci_master_ok}), 32'(ef));
	endtask

	task automatic io_chk(input logic [15:0] a, input logic e);
		@(negedge ref_clk);
		io_valid = 1'h1;
		io_addr = a;
		@(negedge ref_clk);
		io_valid = 1'h0;
		io_addr = ~a;
		check(32'(io_smi), 32'(e));
	endtask

	task automatic pci_chk(input logic [1:0] e);
		@(negedge ref_clk);
		pci_reg_req = 1'h1;
		@(negedge ref_clk);
		pci_reg_req = 1'h0;
		check(32'({pci_reg_grant, pci_reg_refuse}), 32'(e));
	endtask

	initial
	begin
		repeat (12) @(negedge ref_clk);
		rst = 1'h0;
		rd(OFF_MEMORY_TOP, 1'h1, 32'h3fffffff);
		rd(OFF_MAP_AB, 1'h1, 32'h0);
		rd(OFF_MAP_CD, 1'h1, 32'h0);
		rd(OFF_MAP_EF, 1'h1, 32'h0);
		pci_chk(2'h1);
		io_chk(16'h03c5, 1'h0);
		wr(16'h8100, 4'hf, 32'h0);
		rd(16'h8100, 1'h0, 32'h0);
		rd(OFF_MEMORY_TOP, 1'h1, 32'h3fffffff);
		wr(16'h8010, 4'hf, 32'hffffffff);
		rd(16'h8010, 1'h1, 32'h0);
		// Top at code 5, so the limit sits at BFFFFh
		wr(OFF_MEMORY_TOP, 4'hf, 32'h000bffff);
		rd(OFF_MEMORY_TOP, 1'h1, 32'h000bffff);
		wr(OFF_MAP_AB, 4'hf, 32'h1f75c000);
		rd(OFF_MAP_AB, 1'h1, 32'h1f75c000);
		wr(OFF_MAP_CD, 4'hf, 32'h00000090);
		wr(OFF_MAP_EF, 4'hf, 32'hc0000000);
		mem_chk(32'h000b8000, 1'h0, 32'h000b8000, 7'h7d);
		mem_chk(32'h000b0000, 1'h0, 32'h000b0000, 7'h78);
		mem_chk(32'h001b8000, 1'h0, 32'h000b8000, 7'h7d);
		mem_chk(32'h001b8000, 1'h1, 32'h001b8000, 7'h0f);
		mem_chk(32'h000c4000, 1'h0, 32'h000c4000, 7'h29);
		mem_chk(32'h000c0000, 1'h0, 32'h000c0000, 7'h20);
		mem_chk(32'h000fc000, 1'h0, 32'h000fc000, 7'h23);
		io_chk(16'h03c5, 1'h1);
		io_chk(16'h03df, 1'h1);
		io_chk(16'h03b0, 1'h0);
		io_chk(16'h03e0, 1'h0);
		pci_chk(2'h2);
		// Clear lanes 1 and 2 only; the upper window keeps its setting
		wr(OFF_MAP_AB, 4'h6, 32'h0);
		rd(OFF_MAP_AB, 1'h1, 32'h1f000000);
		mem_chk(32'h001b8000, 1'h0, 32'h001b8000, 7'h0f);
		mem_chk(32'h000b0000, 1'h0, 32'h000b0000, 7'h60);
		io_chk(16'h03c5, 1'h0);
		io_chk(16'h03d0, 1'h0);
		pci_chk(2'h1);
		// Mid-run reset must bring back the defaults over programmed values
		rst = 1'h1;
		repeat (2) @(negedge ref_clk);
		rst = 1'h0;
		rd(OFF_MEMORY_TOP, 1'h1, 32'h3fffffff);
		rd(OFF_MAP_AB, 1'h1, 32'h0);
		rd(OFF_MAP_CD, 1'h1, 32'h0);
		rd(OFF_MAP_EF, 1'h1, 32'h0);
		mem_chk(32'h000b8000, 1'h0, 32'h000b8000, 7'h60);
		pci_chk(2'h1);
		test_done();
	end
endmodule
